// ---- rtl/tres_consts.svh ----
// register offsets, field positions and reset values of the reassembly error status bank
// assumes a 16-bit register port with byte addresses
`ifndef TRES_CONSTS_SVH
`define TRES_CONSTS_SVH
// ==========================================================================
// address map
`define TRES_STAT_BASE      16'h6206
`define TRES_HIGH_BASE      16'h6208
`define TRES_LOW_BASE       16'h620a
`define TRES_PORT_STRIDE    16'h0010
`define TRES_IRQ_STAT_ADDR  16'h6400
`define TRES_IRQ_MASK_ADDR  16'h6402
// ==========================================================================
// field positions of the port status/control register
`define TRES_B_LOS_SE       1
`define TRES_B_UOB_SE       2
`define TRES_B_SOB_SE       3
`define TRES_B_PERM_SE      4
`define TRES_B_SIMP_SE      5
`define TRES_B_LOS          6
`define TRES_B_UOB          7
`define TRES_B_SOB          8
`define TRES_B_PERM         9
`define TRES_B_SIMP         10
`define TRES_CH_LSB         11
`define TRES_CH_MSB         15
`define TRES_SE_MASK        16'h003e
`define TRES_FLAG_MASK      16'h07c0
// ==========================================================================
// reset values
`define TRES_STAT_RST       16'h0040
`define TRES_MAP_RST        16'h0000
`define TRES_IRQ_RST        16'h0000
`endif

// ---- rtl/tres_pkg.sv ----
// types shared by the reassembly error status bank
// assumes tres_consts.svh for numbers
package tres_pkg;
  // per-port event inputs, one cycle pulses
  typedef struct packed {
    logic       los;
    logic       uob_err;
    logic       sob_err;
    logic       perm;
    logic       simp;
    logic [4:0] simp_ch;
    logic [4:0] perm_ch;
  } tres_evt_s;
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } tres_req_s;
endpackage

// ---- rtl/tres_bank.sv ----
// per-port error status, service enables and underrun bitmap for tdm reassembly
// assumes events and register strobes are synchronous to core_clk
`timescale 1ns/1ns
`default_nettype none
`include "tres_consts.svh"
// Summary of operation
// - bit 4 set with permanent underrun flag raises the tdm service flag
// - bit 5 set with simple underrun flag raises the tdm service flag
// - bit 6 sticky loss of signal flag, set by input, cleared writing zero
// - loss flag ignores clears until first tdm control register is programmed
// - bit 7 latches unstructured output buffer error until written zero
// - bit 8 latches structured output buffer error until written zero
// - bit 9 latches permanent underrun only when its control enable is set
// - bit 10 latches simple underrun only when its control enable is set
// - bits 15:11 hold channel of most recent enabled simple underrun
// - upper report register holds bitmap bits 31:16, bit n is channel n
// - lower report register holds bitmap bits 15:0, resets to zero
// - enabled permanent underrun on a channel sets its bitmap bit, zero write clears it
// - each port has its own report registers at 6208/620a plus stride
// - bit 1 enables loss of signal service request
// - bits 2 and 3 enable output buffer error service requests
module tres_bank
  import tres_pkg::*;
#(
  parameter int NPORT = 28
)(
  input  wire logic                 core_clk,
  input  wire logic                 rst_b,
  input  wire tres_req_s            req,
  output logic [15:0]               rdata,
  input  wire tres_evt_s [NPORT-1:0] evt,
  input  wire logic [NPORT-1:0]     ctl1_programmed,
  input  wire logic [NPORT-1:0]     perm_ctl_en,
  input  wire logic [NPORT-1:0]     simp_ctl_en,
  output logic                      tdm_service_flag,
  output logic                      irq
);
  logic [15:0] stat_q [NPORT];
  logic [31:0] map_q  [NPORT];
  logic [NPORT-1:0] srv_port;
  logic [1:0]  irq_stat_q;
  logic [1:0]  irq_mask_q;
  logic [1:0]  irq_evt;
  logic        any_ovr;
  logic        any_simp;
  logic [15:0] rd_d;

  // ==========================================================================
  // per-port registers
  genvar p;
  generate
    for (p = 0; p < NPORT; p++)
    begin : g_port
      localparam logic [15:0] SA = 16'(`TRES_STAT_BASE + p * `TRES_PORT_STRIDE);
      localparam logic [15:0] HA = 16'(`TRES_HIGH_BASE + p * `TRES_PORT_STRIDE);
      localparam logic [15:0] LA = 16'(`TRES_LOW_BASE + p * `TRES_PORT_STRIDE);
      logic        wr_s;
      logic        wr_h;
      logic        wr_l;
      logic [15:0] setv;
      logic [15:0] clrv;
      logic [31:0] mset;
      logic [31:0] mclr;
      assign wr_s = req.wr && (req.addr == SA);
      assign wr_h = req.wr && (req.addr == HA);
      assign wr_l = req.wr && (req.addr == LA);
      always_comb
      begin
        setv = 16'h0000;
        setv[`TRES_B_LOS]  = evt[p].los;
        setv[`TRES_B_UOB]  = evt[p].uob_err;
        setv[`TRES_B_SOB]  = evt[p].sob_err;
        setv[`TRES_B_PERM] = evt[p].perm && perm_ctl_en[p];
        setv[`TRES_B_SIMP] = evt[p].simp && simp_ctl_en[p];
        clrv = wr_s ? (~req.wdata & `TRES_FLAG_MASK) : 16'h0000;
        if (!ctl1_programmed[p])
          clrv[`TRES_B_LOS] = 1'b0;
        mset = 32'h0;
        if (evt[p].perm && perm_ctl_en[p])
          mset[evt[p].perm_ch] = 1'b1;
        mclr = {wr_h ? ~req.wdata : 16'h0000, wr_l ? ~req.wdata : 16'h0000};
      end
      always_ff @(posedge core_clk or negedge rst_b)
      begin
        if (!rst_b)
          stat_q[p] <= `TRES_STAT_RST;
        else
        begin
          // set wins over a clear in the same cycle
          stat_q[p][`TRES_B_SIMP:`TRES_B_LOS] <=
            ((stat_q[p][`TRES_B_SIMP:`TRES_B_LOS] & ~clrv[`TRES_B_SIMP:`TRES_B_LOS])
             | setv[`TRES_B_SIMP:`TRES_B_LOS]);
          if (wr_s)
            stat_q[p][`TRES_B_SIMP_SE:`TRES_B_LOS_SE] <= req.wdata[`TRES_B_SIMP_SE:`TRES_B_LOS_SE];
          if (setv[`TRES_B_SIMP])
            stat_q[p][`TRES_CH_MSB:`TRES_CH_LSB] <= evt[p].simp_ch;
        end
      end
      always_ff @(posedge core_clk or negedge rst_b)
      begin
        if (!rst_b)
          map_q[p] <= {`TRES_MAP_RST, `TRES_MAP_RST};
        else
          map_q[p] <= (map_q[p] & ~mclr) | mset;
      end
      // enables bits 1..5 pair with flags bits 6..10
      assign srv_port[p] = |((stat_q[p] & `TRES_SE_MASK) >> `TRES_B_LOS_SE
                             & (stat_q[p] & `TRES_FLAG_MASK) >> `TRES_B_LOS);
    end
  endgenerate

  // ==========================================================================
  // service flag and interrupt
  always_comb
  begin
    any_ovr  = 1'b0;
    any_simp = 1'b0;
    for (int i = 0; i < NPORT; i++)
    begin
      any_ovr  = any_ovr | evt[i].los | evt[i].uob_err | evt[i].sob_err;
      any_simp = any_simp | (evt[i].perm & perm_ctl_en[i]) | (evt[i].simp & simp_ctl_en[i]);
    end
    irq_evt = {any_simp, any_ovr};
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      tdm_service_flag <= 1'b0;
    else
      tdm_service_flag <= |srv_port;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_stat_q <= 2'(`TRES_IRQ_RST);
      irq_mask_q <= 2'(`TRES_IRQ_RST);
    end
    else
    begin
      irq_stat_q <= (irq_stat_q & ~((req.wr && req.addr == `TRES_IRQ_STAT_ADDR) ? req.wdata[1:0] : 2'b00))
                    | irq_evt;
      if (req.wr && req.addr == `TRES_IRQ_MASK_ADDR)
        irq_mask_q <= req.wdata[1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_q & irq_mask_q);
  end

  // ==========================================================================
  // read port, data one cycle after the strobe, unmapped reads zero
  always_comb
  begin
    rd_d = 16'h0000;
    if (req.addr == `TRES_IRQ_STAT_ADDR)
      rd_d = {14'h0000, irq_stat_q};
    else if (req.addr == `TRES_IRQ_MASK_ADDR)
      rd_d = {14'h0000, irq_mask_q};
    for (int i = 0; i < NPORT; i++)
    begin
      if (req.addr == 16'(`TRES_STAT_BASE + i * `TRES_PORT_STRIDE))
        rd_d = stat_q[i];
      if (req.addr == 16'(`TRES_HIGH_BASE + i * `TRES_PORT_STRIDE))
        rd_d = map_q[i][31:16];
      if (req.addr == 16'(`TRES_LOW_BASE + i * `TRES_PORT_STRIDE))
        rd_d = map_q[i][15:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata <= 16'h0000;
    else if (req.rd)
      rdata <= rd_d;
    else
      rdata <= 16'h0000;
  end

  // ==========================================================================
  // checks
  // the underrun gates are exercised on the last port, so most checks watch it
  localparam int          LASTP   = NPORT - 1;
  localparam logic [15:0] LAST_SA = 16'(`TRES_STAT_BASE + LASTP * `TRES_PORT_STRIDE);
  localparam logic [15:0] LAST_HA = 16'(`TRES_HIGH_BASE + LASTP * `TRES_PORT_STRIDE);
  localparam logic [15:0] LAST_LA = 16'(`TRES_LOW_BASE + LASTP * `TRES_PORT_STRIDE);
  logic        wr_last_stat;
  logic        wr_last_high;
  logic        wr_last_low;
  logic        perm_hit_last;
  logic        simp_hit_last;
  logic [15:0] last_stat;
  logic [31:0] last_map;
  assign wr_last_stat  = req.wr && (req.addr == LAST_SA);
  assign wr_last_high  = req.wr && (req.addr == LAST_HA);
  assign wr_last_low   = req.wr && (req.addr == LAST_LA);
  assign perm_hit_last = evt[LASTP].perm && perm_ctl_en[LASTP];
  assign simp_hit_last = evt[LASTP].simp && simp_ctl_en[LASTP];
  assign last_stat     = stat_q[LASTP];
  assign last_map      = map_q[LASTP];

  sequence s_simp_evt_last;
    simp_hit_last;
  endsequence
  sequence s_perm_evt_last;
    perm_hit_last;
  endsequence
  sequence s_stat_read_last;
    req.rd && (req.addr == LAST_SA);
  endsequence
  sequence s_stat_write_last;
    wr_last_stat;
  endsequence

  // ==========================================================================
  // status flags, set and clear
  a_los_clear_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
    stat_q[0][`TRES_B_LOS] && !ctl1_programmed[0] |=> stat_q[0][`TRES_B_LOS])
    else $error("loss flag cleared before control programmed");
  a_los_clear_ok: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_stat_write_last ##0 (ctl1_programmed[LASTP] && !req.wdata[`TRES_B_LOS] && !evt[LASTP].los) |=> !last_stat[`TRES_B_LOS])
    else $error("loss flag kept after clear");
  a_los_set: assert property (@(posedge core_clk) disable iff (!rst_b)
    evt[LASTP].los |=> last_stat[`TRES_B_LOS])
    else $error("loss flag not set");
  a_uob_set: assert property (@(posedge core_clk) disable iff (!rst_b)
    evt[LASTP].uob_err |=> last_stat[`TRES_B_UOB])
    else $error("unstructured buffer flag not set");
  a_uob_sticky: assert property (@(posedge core_clk) disable iff (!rst_b)
    last_stat[`TRES_B_UOB] && !wr_last_stat |=> last_stat[`TRES_B_UOB])
    else $error("unstructured buffer flag dropped");
  a_flag_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_stat_write_last ##0 (!req.wdata[`TRES_B_UOB] && !evt[LASTP].uob_err) |=> !last_stat[`TRES_B_UOB])
    else $error("unstructured buffer flag kept after clear");
  a_sob_set: assert property (@(posedge core_clk) disable iff (!rst_b)
    evt[LASTP].sob_err |=> last_stat[`TRES_B_SOB])
    else $error("structured buffer flag not set");
  a_sob_sticky: assert property (@(posedge core_clk) disable iff (!rst_b)
    last_stat[`TRES_B_SOB] && !wr_last_stat |=> last_stat[`TRES_B_SOB])
    else $error("structured buffer flag dropped");
  a_flag_keep: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_stat_write_last ##0 (req.wdata[`TRES_B_SOB] && last_stat[`TRES_B_SOB]) |=> last_stat[`TRES_B_SOB])
    else $error("flag lost on a one write");
  a_perm_latch: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_perm_evt_last |=> last_stat[`TRES_B_PERM])
    else $error("permanent underrun not latched");
  a_perm_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
    !last_stat[`TRES_B_PERM] && !perm_hit_last |=> !last_stat[`TRES_B_PERM])
    else $error("permanent flag set without enable");
  a_simp_latch: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_simp_evt_last |=> last_stat[`TRES_B_SIMP] && last_stat[`TRES_CH_MSB:`TRES_CH_LSB] == $past(evt[LASTP].simp_ch))
    else $error("simple underrun not latched");
  a_simp_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
    !last_stat[`TRES_B_SIMP] && !simp_hit_last |=> !last_stat[`TRES_B_SIMP])
    else $error("simple flag set without enable");
  a_ch_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    !simp_hit_last |=> $stable(last_stat[`TRES_CH_MSB:`TRES_CH_LSB]))
    else $error("channel field changed without simple underrun");
  a_se_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_stat_write_last |=> last_stat[`TRES_B_SIMP_SE:`TRES_B_LOS_SE] == $past(req.wdata[`TRES_B_SIMP_SE:`TRES_B_LOS_SE]))
    else $error("service enables not written");
  a_se_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    !wr_last_stat |=> $stable(last_stat[`TRES_B_SIMP_SE:`TRES_B_LOS_SE]))
    else $error("service enables changed without write");

  // ==========================================================================
  // underrun bitmap
  a_map_set: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_perm_evt_last |=> last_map[$past(evt[LASTP].perm_ch)])
    else $error("bitmap bit not set");
  a_map_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    !perm_hit_last && !wr_last_high && !wr_last_low |=> $stable(last_map))
    else $error("bitmap changed without event or write");
  a_map_low_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
    wr_last_low && !perm_hit_last |=> last_map[15:0] == ($past(last_map[15:0]) & $past(req.wdata)))
    else $error("low bitmap write wrong");
  a_map_high_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
    wr_last_high && !perm_hit_last |=> last_map[31:16] == ($past(last_map[31:16]) & $past(req.wdata)))
    else $error("high bitmap write wrong");
  a_map_port0: assert property (@(posedge core_clk) disable iff (!rst_b)
    !(evt[0].perm && perm_ctl_en[0]) && !(req.wr && (req.addr == `TRES_HIGH_BASE || req.addr == `TRES_LOW_BASE)) |=> $stable(map_q[0]))
    else $error("port zero bitmap disturbed by another port");

  // ==========================================================================
  // service flag and interrupt
  a_srv_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
    last_stat[`TRES_B_PERM] && last_stat[`TRES_B_PERM_SE] |=> tdm_service_flag)
    else $error("service flag missing");
  a_srv_simp: assert property (@(posedge core_clk) disable iff (!rst_b)
    last_stat[`TRES_B_SIMP] && last_stat[`TRES_B_SIMP_SE] |=> tdm_service_flag)
    else $error("service flag missing for simple underrun");
  a_srv_los: assert property (@(posedge core_clk) disable iff (!rst_b)
    last_stat[`TRES_B_LOS] && last_stat[`TRES_B_LOS_SE] |=> tdm_service_flag)
    else $error("service flag missing for loss of signal");
  a_srv_outbuf: assert property (@(posedge core_clk) disable iff (!rst_b)
    (last_stat[`TRES_B_UOB] && last_stat[`TRES_B_UOB_SE]) || (last_stat[`TRES_B_SOB] && last_stat[`TRES_B_SOB_SE]) |=> tdm_service_flag)
    else $error("service flag missing for buffer error");
  a_srv_port0: assert property (@(posedge core_clk) disable iff (!rst_b)
    stat_q[0][`TRES_B_LOS] && stat_q[0][`TRES_B_LOS_SE] |=> tdm_service_flag)
    else $error("service flag missing for port zero");
  a_srv_idle: assert property (@(posedge core_clk) disable iff (!rst_b)
    !(|srv_port) |=> !tdm_service_flag)
    else $error("service flag without enabled flag");
  a_irq_off: assert property (@(posedge core_clk) disable iff (!rst_b)
    !(|irq_mask_q) |=> !irq)
    else $error("interrupt with all events masked");
  a_irq_sticky: assert property (@(posedge core_clk) disable iff (!rst_b)
    irq_stat_q[0] && !(req.wr && req.addr == `TRES_IRQ_STAT_ADDR) |=> irq_stat_q[0])
    else $error("interrupt status dropped");
  a_irq_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.wr && req.addr == `TRES_IRQ_STAT_ADDR && req.wdata[1:0] == 2'b11 && !(|irq_evt) |=> irq_stat_q == 2'b00)
    else $error("interrupt status not cleared");
  a_irq_mask_wr: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.wr && req.addr == `TRES_IRQ_MASK_ADDR |=> irq_mask_q == $past(req.wdata[1:0]))
    else $error("interrupt mask not written");

  // ==========================================================================
  // read port
  a_rd_stat: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_stat_read_last |=> rdata == $past(last_stat))
    else $error("status read data wrong");
  a_rd_high: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.rd && req.addr == LAST_HA |=> rdata == $past(last_map[31:16]))
    else $error("high bitmap read data wrong");
  a_rd_low: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.rd && req.addr == LAST_LA |=> rdata == $past(last_map[15:0]))
    else $error("low bitmap read data wrong");
  a_rd_idle: assert property (@(posedge core_clk) disable iff (!rst_b)
    !req.rd |=> rdata == 16'h0000)
    else $error("read data outside read cycle");
endmodule // tres_bank
`default_nettype wire

// ---- verification/tres_bank_tb.sv ----
// testbench for the reassembly error status bank: register port tasks, event pulses, self-checking
// assumes tres_pkg, tres_consts.svh and the bank with its own assertions
`timescale 1ns/1ns
`default_nettype none
`include "tres_consts.svh"
module tres_bank_tb
  import tres_pkg::*;
;
  // ==========================================================================
  // clock, reset and stimulus signals
  logic             core_clk;
  logic             rst_b;
  tres_req_s        req;
  logic [15:0]      rdata;
  tres_evt_s [1:0]  evt;
  logic [1:0]       ctl1_programmed;
  logic [1:0]       perm_ctl_en;
  logic [1:0]       simp_ctl_en;
  logic             tdm_service_flag;
  logic             irq;
  int               num_errors;
  int               total_checks;
  logic [15:0]      en;
  logic [15:0]      fl;
  logic [15:0]      chx;
  localparam logic [15:0] ST1 = `TRES_STAT_BASE + `TRES_PORT_STRIDE;
  localparam logic [15:0] HI1 = `TRES_HIGH_BASE + `TRES_PORT_STRIDE;
  localparam logic [15:0] LO1 = `TRES_LOW_BASE + `TRES_PORT_STRIDE;

  tres_bank #(.NPORT(2)) i_dut (
    .core_clk         (core_clk),
    .rst_b            (rst_b),
    .req              (req),
    .rdata            (rdata),
    .evt              (evt),
    .ctl1_programmed  (ctl1_programmed),
    .perm_ctl_en      (perm_ctl_en),
    .simp_ctl_en      (simp_ctl_en),
    .tdm_service_flag (tdm_service_flag),
    .irq              (irq)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ==========================================================================
  // tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    req <= '0;
  endtask
  task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    req <= '0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic pulse(input int k, input logic [4:0] ch, input logic gate);
    tres_evt_s v;
    v = '0;
    v.simp_ch = ch;
    v.perm_ch = ch;
    case (k)
      0: v.los = 1'b1;
      1: v.uob_err = 1'b1;
      2: v.sob_err = 1'b1;
      3: v.perm = 1'b1;
      default: v.simp = 1'b1;
    endcase
    @(posedge core_clk);
    perm_ctl_en[1] <= gate;
    simp_ctl_en[1] <= gate;
    evt[1] <= v;
    @(posedge core_clk);
    evt[1] <= '0;
  endtask
  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================================
  // watchdog
  initial
  begin
    #200000;
    num_errors++;
    close_out();
  end
  // ==========================================================================
  // tests
  initial
  begin
    rst_b = 1'b0;
    req = '0;
    evt = '0;
    ctl1_programmed = 2'b10;
    perm_ctl_en = 2'b00;
    simp_ctl_en = 2'b00;
    num_errors = 0;
    total_checks = 0;
    chx = 16'h0000;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    rchk(`TRES_STAT_BASE, `TRES_STAT_RST);
    rchk(`TRES_LOW_BASE, `TRES_MAP_RST);
    wr(`TRES_STAT_BASE, 16'h0002);
    settle();
    chk({15'h0000, tdm_service_flag}, 16'h0001);
    rchk(`TRES_STAT_BASE, 16'h0042);
    @(posedge core_clk);
    ctl1_programmed[0] <= 1'b1;
    wr(`TRES_STAT_BASE, 16'h0000);
    settle();
    chk({15'h0000, tdm_service_flag}, 16'h0000);
    rchk(`TRES_STAT_BASE, 16'h0000);
    wr(ST1, 16'h0000);
    wr(`TRES_IRQ_MASK_ADDR, 16'h0002);
    for (int k = 0; k < 5; k++)
    begin
      en = 16'h0001 << (1 + k);
      fl = 16'h0001 << (6 + k);
      wr(ST1, en);
      if (k > 2)
      begin
        pulse(k, 5'h00, 1'b0);
        settle();
        chk({15'h0000, tdm_service_flag}, 16'h0000);
      end
      pulse(k, 5'h10 + 5'(k), 1'b1);
      settle();
      if (k == 4)
        chx = 16'ha000;
      chk({15'h0000, tdm_service_flag}, 16'h0001);
      chk({15'h0000, irq}, {15'h0000, k > 2});
      rchk(`TRES_IRQ_STAT_ADDR, (k > 2) ? 16'h0002 : 16'h0001);
      wr(ST1, en | fl);
      rchk(ST1, en | fl | chx);
      wr(`TRES_IRQ_STAT_ADDR, 16'h0003);
      wr(ST1, en);
      settle();
      chk({14'h0000, tdm_service_flag, irq}, 16'h0000);
      rchk(ST1, en | chx);
    end
    rchk(HI1, 16'h0008);
    rchk(`TRES_HIGH_BASE, 16'h0000);
    @(posedge core_clk);
    perm_ctl_en[1] <= 1'b1;
    fork
      wr(LO1, 16'h0000);
      pulse(3, 5'h02, 1'b1);
    join
    rchk(LO1, 16'h0004);
    wr(LO1, 16'hffff);
    wr(HI1, 16'hfff7);
    rchk(LO1, 16'h0004);
    rchk(HI1, 16'h0000);
    wr(16'h7000, 16'hffff);
    rchk(16'h7000, 16'h0000);
    close_out();
  end
endmodule // tres_bank_tb
`default_nettype wire
